// ===== logic/tmcs_core.sv
// tape motion command sequencer with sense early end and end status
`timescale 1ns/1ps

module tmcs_core
  import tmcs_pkg::*;
#(
  parameter int unsigned MARK_ERASE_CYCLES = MARK_ERASE_CYC,
  parameter int unsigned FORCED_DELAY_CYCLES = FORCED_DELAY_CYC,
  parameter int unsigned START_DELAY_CYCLES = START_DELAY_CYC
)
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire tmcs_cmd_req_t cmd_in,
  input wire tmcs_chan_in_t chan_in,
  input wire logic [7:0] sense_byte_in,
  input wire tmcs_tu_in_t tu_in,
  input wire logic [NUM_UNITS-1:0] tu_free_in,
  output tmcs_chan_out_t chan_out,
  output tmcs_tu_out_t tu_out,
  output logic [2:0] sense_idx_out,
  output logic sel_ready_out
);

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_INIT = 4'h1,
    ST_SNS_LOAD = 4'h3,
    ST_SNS_WAIT = 4'h2,
    ST_END = 4'h6,
    ST_REW = 4'h7,
    ST_RUN = 4'h5,
    ST_INT_REQ = 4'h4,
    ST_INT_STAT = 4'hC
  } tmcs_state_t;

  typedef enum logic [1:0] {
    PH_DELAY = 2'h0,
    PH_START = 2'h1,
    PH_MARK = 2'h3,
    PH_CHECK = 2'h2
  } tmcs_phase_t;

  function automatic logic is_motion(input tmcs_cmd_t c);
    is_motion = (c != TMCS_CMD_NONE) && (c != TMCS_CMD_SENSE);
  endfunction

  function automatic logic is_space(input tmcs_cmd_t c);
    is_space = (c == TMCS_CMD_SPACE_BLK) || (c == TMCS_CMD_SPACE_FILE);
  endfunction

  function automatic logic [TMR_W-1:0] cycles(input int unsigned n);
    cycles = TMR_W'(n - 1);
  endfunction

  tmcs_state_t state_q, state_d;
  tmcs_phase_t ph_q, ph_d;
  tmcs_cmd_t cmd_q, cmd_d;
  logic [UNIT_W-1:0] unit_q, unit_d;
  logic back_q, back_d;
  logic [7:0] stat_q, stat_d;
  logic [7:0] stk_q, stk_d;
  logic stack_q, stack_d;
  logic [2:0] idx_q, idx_d;
  logic [TMR_W-1:0] tmr_q, tmr_d;
  logic mark_q, mark_d;
  logic ifree_q, ifree_d;
  logic ack_d;
  logic served_q;
  logic [UNIT_W-1:0] scan_q;
  logic hit;
  tmcs_chan_out_t chan_q;
  tmcs_tu_out_t tu_q;
  logic ready_q;

  assign hit = tu_free_in[scan_q];
  assign chan_out = chan_q;
  assign tu_out = tu_q;
  assign sense_idx_out = idx_q;
  assign sel_ready_out = ready_q;

  // unit free stops the scanner, otherwise it walks all addresses
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      scan_q <= '0;
    else if (!hit)
      scan_q <= scan_q + UNIT_W'(1);
  end

  always_comb
  begin
    state_d = state_q;
    ph_d = ph_q;
    cmd_d = cmd_q;
    unit_d = unit_q;
    back_d = back_q;
    stat_d = stat_q;
    stk_d = stk_q;
    stack_d = stack_q;
    idx_d = idx_q;
    tmr_d = (tmr_q == '0) ? tmr_q : tmr_q - TMR_W'(1);
    mark_d = mark_q;
    ifree_d = ifree_q;
    ack_d = 1'b0;
    unique case (state_q)
      ST_IDLE:
      begin
        if (hit && !served_q)
        begin
          // pending device end goes out before any new selection
          state_d = ST_INT_REQ;
          stat_d = ST_DEV_END;
          ifree_d = 1'b1;
        end
        else if (cmd_in.start && cmd_in.code != TMCS_CMD_NONE)
        begin
          state_d = ST_INIT;
          cmd_d = cmd_in.code;
          unit_d = cmd_in.unit;
          back_d = cmd_in.backward;
          ifree_d = 1'b0;
          if (cmd_in.code == TMCS_CMD_SENSE)
            stat_d = stack_q ? (stk_q | ST_BUSY) : ST_NONE;
          else
            stat_d = ST_CH_END;
        end
      end
      ST_INIT:
      begin
        if (chan_in.svc_out || chan_in.cmd_tag)
        begin
          if (is_motion(cmd_q))
          begin
            // either answer starts a motion command
            mark_d = 1'b0;
            ph_d = PH_DELAY;
            if (cmd_q == TMCS_CMD_REWIND || cmd_q == TMCS_CMD_UNLOAD)
              state_d = ST_REW;
            else
              state_d = ST_RUN;
            if (cmd_q == TMCS_CMD_MARK)
              tmr_d = cycles(MARK_ERASE_CYCLES);
            else
              tmr_d = cycles(FORCED_DELAY_CYCLES);
          end
          else if (stack_q)
          begin
            // long busy hands over the held status either way
            state_d = ST_IDLE;
            stack_d = 1'b0;
          end
          else if (chan_in.cmd_tag)
          begin
            state_d = ST_IDLE;
            stack_d = 1'b1;
            stk_d = stat_q;
          end
          else
          begin
            state_d = ST_SNS_LOAD;
            idx_d = SENSE_FIRST;
          end
        end
      end
      ST_SNS_LOAD:
        state_d = ST_SNS_WAIT;
      ST_SNS_WAIT:
      begin
        if (chan_in.cmd_tag)
        begin
          state_d = ST_END;
          stat_d = ST_CH_END | ST_DEV_END;
        end
        else if (chan_in.svc_out && idx_q == SENSE_LAST)
        begin
          state_d = ST_END;
          stat_d = ST_CH_END | ST_DEV_END;
        end
        else if (chan_in.svc_out)
        begin
          state_d = ST_SNS_LOAD;
          idx_d = idx_q + 3'h1;
        end
      end
      ST_END:
      begin
        if (chan_in.svc_out || chan_in.cmd_tag)
          state_d = ST_IDLE;
        if (chan_in.cmd_tag)
        begin
          stack_d = 1'b1;
          stk_d = stat_q;
        end
      end
      ST_REW:
      begin
        if (tu_in.rewinding && cmd_q == TMCS_CMD_UNLOAD)
        begin
          state_d = ST_INT_REQ;
          stat_d = ST_DEV_END | ST_UNIT_CHK | ST_CTRL_END;
        end
        else if (tu_in.rewinding)
          state_d = ST_IDLE;
      end
      ST_RUN:
      begin
        if (tu_in.mark_seen)
          mark_d = 1'b1;
        unique case (cmd_q)
          TMCS_CMD_ERASE:
            if (tmr_q == '0)
            begin
              state_d = ST_INT_REQ;
              stat_d = ST_DEV_END;
            end
          TMCS_CMD_MARK:
          begin
            unique case (ph_q)
              PH_DELAY:
                if (tmr_q == '0)
                begin
                  ph_d = PH_START;
                  tmr_d = cycles(START_DELAY_CYCLES);
                end
              PH_START:
                if (tmr_q == '0)
                  ph_d = PH_MARK;
              PH_MARK:
                ph_d = PH_CHECK;
              PH_CHECK:
              begin
                state_d = ST_INT_REQ;
                stat_d = ST_DEV_END;
              end
            endcase
          end
          TMCS_CMD_SPACE_BLK:
            if (tu_in.block_end)
            begin
              state_d = ST_INT_REQ;
              stat_d = (mark_q || tu_in.mark_seen) ?
                (ST_DEV_END | ST_UNIT_EXC) : ST_DEV_END;
            end
          TMCS_CMD_SPACE_FILE:
            if (tu_in.block_end && (mark_q || tu_in.mark_seen))
            begin
              state_d = ST_INT_REQ;
              stat_d = ST_DEV_END;
            end
          default:
            state_d = ST_IDLE;
        endcase
      end
      ST_INT_REQ:
        if (chan_in.int_grant)
          state_d = ST_INT_STAT;
      ST_INT_STAT:
      begin
        if (chan_in.svc_out || chan_in.cmd_tag)
        begin
          state_d = ST_IDLE;
          ack_d = ifree_q;
          ifree_d = 1'b0;
        end
        if (chan_in.cmd_tag)
        begin
          stack_d = 1'b1;
          stk_d = stat_q;
        end
      end
      default:
        state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_q <= ST_IDLE;
      ph_q <= PH_DELAY;
      cmd_q <= TMCS_CMD_NONE;
      unit_q <= '0;
      back_q <= 1'b0;
      tmr_q <= '0;
      mark_q <= 1'b0;
      ifree_q <= 1'b0;
      idx_q <= SENSE_FIRST;
    end
    else
    begin
      state_q <= state_d;
      ph_q <= ph_d;
      cmd_q <= cmd_d;
      unit_q <= unit_d;
      back_q <= back_d;
      tmr_q <= tmr_d;
      mark_q <= mark_d;
      ifree_q <= ifree_d;
      idx_q <= idx_d;
    end
  end

  // status kept apart so a rejected byte survives later commands
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      stat_q <= ST_NONE;
      stk_q <= ST_NONE;
      stack_q <= 1'b0;
    end
    else
    begin
      stat_q <= stat_d;
      stk_q <= stk_d;
      stack_q <= stack_d;
    end
  end

  // a served unit stays free a few cycles; ignore it until it drops
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      served_q <= 1'b0;
    else if (ack_d)
      served_q <= 1'b1;
    else if (!hit)
      served_q <= 1'b0;
  end

  // channel tags follow the next state so they line up with state_q
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      chan_q <= '0;
      ready_q <= 1'b0;
    end
    else
    begin
      chan_q.op_in <= state_d inside {ST_INIT, ST_SNS_LOAD, ST_SNS_WAIT,
        ST_END, ST_INT_STAT};
      chan_q.stat_in <= state_d inside {ST_INIT, ST_END, ST_INT_STAT};
      chan_q.svc_in <= state_d == ST_SNS_WAIT;
      chan_q.req_in <= state_d == ST_INT_REQ;
      if (state_q == ST_SNS_LOAD)
        chan_q.bus_in <= sense_byte_in;
      else if (state_d inside {ST_INIT, ST_END, ST_INT_STAT})
        chan_q.bus_in <= stat_d;
      ready_q <= state_d == ST_IDLE;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      tu_q <= '0;
    end
    else
    begin
      tu_q.rewind <= state_d == ST_REW;
      tu_q.write <= state_d == ST_RUN &&
        (cmd_d == TMCS_CMD_ERASE || cmd_d == TMCS_CMD_MARK);
      tu_q.move <= state_d == ST_RUN;
      tu_q.backward <= state_d == ST_RUN && back_d;
      tu_q.rd_check <= !(state_d == ST_RUN && is_space(cmd_d));
      // mark and its check character are the same byte
      tu_q.wr_strobe <= state_d == ST_RUN && cmd_d == TMCS_CMD_MARK &&
        (ph_d == PH_MARK || ph_d == PH_CHECK);
      tu_q.wr_data <= tu_in.seven_track ? MARK_SEVEN : MARK_NINE;
      // the acknowledge must reach the freed unit, not the last command's
      tu_q.unit <= (ifree_d || ack_d) ? scan_q : unit_d;
      tu_q.free_ack <= ack_d;
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  init_chan_end_a: assert property (
    state_q == ST_INIT && is_motion(cmd_q) |->
      chan_q.stat_in && (chan_q.bus_in & ST_CH_END) != ST_NONE)
    else $error("motion initial status lacks channel end");
  early_end_a: assert property (
    state_q == ST_SNS_WAIT && chan_in.cmd_tag |=>
      state_q == ST_END && !chan_q.svc_in && chan_q.stat_in)
    else $error("early end did not stop sense");
  sense_last_a: assert property (
    state_q == ST_SNS_WAIT && chan_in.svc_out && !chan_in.cmd_tag &&
      idx_q == SENSE_LAST |=> state_q == ST_END ##1 idx_q == SENSE_LAST)
    else $error("sixth byte not followed by ending");
  motion_drop_a: assert property (
    state_q == ST_INIT && is_motion(cmd_q) &&
      (chan_in.svc_out || chan_in.cmd_tag) |=>
      !chan_q.op_in && (tu_q.rewind || tu_q.move))
    else $error("motion start kept operational in");
  rewind_free_a: assert property (
    state_q == ST_REW && tu_in.rewinding && cmd_q == TMCS_CMD_REWIND |=>
      ready_q && !tu_q.rewind)
    else $error("rewind did not release unit");
  unload_int_a: assert property (
    state_q == ST_REW && tu_in.rewinding && cmd_q == TMCS_CMD_UNLOAD |=>
      chan_q.req_in && stat_q == (ST_DEV_END | ST_UNIT_CHK | ST_CTRL_END))
    else $error("unload second status missing");
  int_blocks_a: assert property (
    chan_q.req_in |-> !ready_q ##1 !ready_q)
    else $error("selection open during interrupt");
  scan_hold_a: assert property (
    hit |=> scan_q == $past(scan_q))
    else $error("scanner left a free unit");
  scan_step_a: assert property (
    !hit |=> scan_q == $past(scan_q) + UNIT_W'(1))
    else $error("scanner did not step");
  space_end_a: assert property (
    state_q == ST_RUN && cmd_q == TMCS_CMD_SPACE_BLK && tu_in.block_end |=>
      chan_q.req_in && (stat_q & ST_DEV_END) != ST_NONE && !tu_q.move)
    else $error("space block end status wrong");
  mark_byte_a: assert property (
    tu_q.wr_strobe |->
      tu_q.wr_data == ($past(tu_in.seven_track) ? MARK_SEVEN : MARK_NINE))
    else $error("tape mark pattern wrong");
  space_check_a: assert property (
    state_q == ST_RUN && is_space(cmd_q) |-> !tu_q.rd_check && tu_q.move)
    else $error("read checks live while spacing");

  early_end_c: cover property (
    state_q == ST_SNS_WAIT && chan_in.cmd_tag && idx_q == 3'h2);
  unload_c: cover property (
    state_q == ST_INT_STAT && stat_q[1] && chan_in.svc_out);
  mark_c: cover property (tu_q.wr_strobe ##1 tu_q.wr_strobe);
  free_c: cover property (tu_q.free_ack);

endmodule

// ===== include/tmcs_pkg.sv
// constants, commands and carrier types of the tape motion sequencer
package tmcs_pkg;

  localparam int UNIT_W = 3;
  localparam int NUM_UNITS = 8;
  localparam int TMR_W = 25;

  // command codes as handed over by the selection logic
  typedef enum logic [2:0] {
    TMCS_CMD_NONE = 3'h0,
    TMCS_CMD_SENSE = 3'h1,
    TMCS_CMD_REWIND = 3'h2,
    TMCS_CMD_UNLOAD = 3'h3,
    TMCS_CMD_ERASE = 3'h4,
    TMCS_CMD_MARK = 3'h5,
    TMCS_CMD_SPACE_BLK = 3'h6,
    TMCS_CMD_SPACE_FILE = 3'h7
  } tmcs_cmd_t;

  // status byte, bit 0 of the channel byte is the msb
  localparam logic [7:0] ST_MOD = 8'h40;
  localparam logic [7:0] ST_CTRL_END = 8'h20;
  localparam logic [7:0] ST_BUSY = 8'h10;
  localparam logic [7:0] ST_CH_END = 8'h08;
  localparam logic [7:0] ST_DEV_END = 8'h04;
  localparam logic [7:0] ST_UNIT_CHK = 8'h02;
  localparam logic [7:0] ST_UNIT_EXC = 8'h01;
  localparam logic [7:0] ST_NONE = 8'h00;

  // tape mark byte, byte bit n carries track n
  localparam logic [7:0] MARK_NINE = 8'hC8;
  localparam logic [7:0] MARK_SEVEN = 8'hF0;

  localparam logic [2:0] SENSE_LAST = 3'h5;
  localparam logic [2:0] SENSE_FIRST = 3'h0;

  // timing
  localparam int CLK_KHZ = 100000;
  localparam int MARK_ERASE_MS = 204;
  localparam int MARK_ERASE_CYC = MARK_ERASE_MS * CLK_KHZ;
  localparam int FORCED_DELAY_CYC = 1000;
  localparam int START_DELAY_CYC = 500;

  typedef struct packed {
    logic start;
    tmcs_cmd_t code;
    logic [UNIT_W-1:0] unit;
    logic backward;
  } tmcs_cmd_req_t;

  typedef struct packed {
    logic svc_out;
    logic cmd_tag;
    logic int_grant;
  } tmcs_chan_in_t;

  typedef struct packed {
    logic op_in;
    logic stat_in;
    logic svc_in;
    logic req_in;
    logic [7:0] bus_in;
  } tmcs_chan_out_t;

  typedef struct packed {
    logic rewinding;
    logic block_end;
    logic mark_seen;
    logic seven_track;
  } tmcs_tu_in_t;

  typedef struct packed {
    logic rewind;
    logic write;
    logic move;
    logic backward;
    logic rd_check;
    logic wr_strobe;
    logic [7:0] wr_data;
    logic [UNIT_W-1:0] unit;
    logic free_ack;
  } tmcs_tu_out_t;

endpackage

// ===== test/tmcs_chan_model.sv
// host channel model answering status, service and request tags
`timescale 1ns/1ps
module tmcs_chan_model
  import tmcs_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire tmcs_chan_out_t chan_in,
  input wire logic reject_in,
  input wire logic [2:0] keep_in,
  input wire logic [3:0] delay_in,
  output tmcs_chan_in_t chan_out
);
  logic [3:0] wait_q;
  logic [2:0] taken_q;

  // hold-off after each answer so a tag is never answered twice
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      chan_out <= '0;
      wait_q <= 4'h0;
      taken_q <= 3'h0;
    end
    else
    begin
      chan_out <= '0;
      if (!chan_in.op_in && !chan_in.req_in)
        taken_q <= 3'h0;
      if (wait_q != 4'h0)
        wait_q <= wait_q - 4'h1;
      else if (chan_in.req_in)
      begin
        chan_out.int_grant <= 1'b1;
        wait_q <= delay_in + 4'h2;
      end
      else if (chan_in.stat_in)
      begin
        chan_out.cmd_tag <= reject_in;
        chan_out.svc_out <= !reject_in;
        wait_q <= delay_in + 4'h2;
      end
      else if (chan_in.svc_in)
      begin
        chan_out.cmd_tag <= (taken_q == keep_in);
        chan_out.svc_out <= (taken_q != keep_in);
        taken_q <= taken_q + 3'h1;
        wait_q <= delay_in + 4'h2;
      end
    end
  end
endmodule

// ===== test/tmcs_core_tb.sv
// bench of the tape motion sequencer with tape unit model and checks
`timescale 1ns/1ps
module tmcs_core_tb;
  import tmcs_pkg::*;
  localparam int MER = 40;
  localparam int LPD = 8;
  localparam int STD = 5;
  logic clk_in;
  logic rst_in;
  tmcs_cmd_req_t cmd;
  tmcs_chan_in_t ch_i;
  tmcs_chan_out_t ch_o;
  tmcs_chan_out_t pv;
  tmcs_tu_in_t tu_i;
  tmcs_tu_out_t tu_o;
  logic [7:0] sense_b;
  logic [7:0] pat [6];
  logic [7:0] free;
  logic [2:0] idx;
  logic rdy, rej, pmv, bwd, b, f;
  logic [2:0] keep, u, v;
  logic [3:0] dly;
  logic [7:0] e;
  logic [31:0] rng = 32'h34;
  logic [7:0] st_q [$];
  logic [7:0] sn_q [$];
  logic [7:0] wr_q [$];
  logic [2:0] un_q [$];
  int failures, samples_checked, cyc, rises, viol, mv_t, rq_t, sb_t;
  int bc, bn, blen, mark_at, ends, n;

  assign sense_b = pat[idx];

  tmcs_core #(.MARK_ERASE_CYCLES(MER), .FORCED_DELAY_CYCLES(LPD),
    .START_DELAY_CYCLES(STD)) u_tmcs_core (.clk_in(clk_in),
    .rst_in(rst_in), .cmd_in(cmd), .chan_in(ch_i), .sense_byte_in(sense_b),
    .tu_in(tu_i), .tu_free_in(free), .chan_out(ch_o), .tu_out(tu_o),
    .sense_idx_out(idx), .sel_ready_out(rdy));

  tmcs_chan_model u_tmcs_chan_model (.clk_in(clk_in), .rst_in(rst_in),
    .chan_in(ch_o), .reject_in(rej), .keep_in(keep), .delay_in(dly),
    .chan_out(ch_i));

  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  function automatic logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1)
    begin
      failures++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask

  task automatic summarize();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic clr();
    st_q.delete();
    sn_q.delete();
    wr_q.delete();
    un_q.delete();
    rises = 0;
    ends = 0;
    sb_t = 0;
    rq_t = 0;
    dly <= 4'(rnd() % 4);
  endtask

  task automatic issue(input tmcs_cmd_t c, input logic [2:0] a,
                       input logic bk);
    int t;
    t = 0;
    while (rdy !== 1'b1 && t < 5000)
    begin
      @(posedge clk_in);
      t++;
    end
    cmd <= '{1'b1, c, a, bk};
    @(posedge clk_in);
    cmd.start <= 1'b0;
  endtask

  // two edges first: the taking edge has not yet dropped the ready flag
  task automatic wait_idle();
    int t;
    t = 0;
    repeat (2) @(posedge clk_in);
    while (!(rdy === 1'b1 && ch_o.op_in === 1'b0 && free === 8'h00)
           && t < 5000)
    begin
      @(posedge clk_in);
      t++;
    end
    chk(t < 5000, "controller never returned to idle");
  endtask

  // channel and unit side monitor
  always @(posedge clk_in)
  begin
    cyc++;
    if (ch_o.stat_in && !pv.stat_in)
      st_q.push_back(ch_o.bus_in);
    if (ch_o.svc_in && !pv.svc_in)
      sn_q.push_back(ch_o.bus_in);
    if (ch_o.req_in && !pv.req_in)
    begin
      un_q.push_back(tu_o.unit);
      if (rq_t == 0)
        rq_t = cyc;
    end
    if (tu_o.move && !pmv)
    begin
      if (rises == 0)
        mv_t = cyc;
      rises++;
      bwd = tu_o.backward;
    end
    if ((tu_o.move && !pmv || tu_o.rewind) && ch_o.op_in)
      viol++;
    if (tu_o.move && !tu_o.write && (tu_o.rd_check || ch_o.svc_in))
      viol++;
    if (ch_o.req_in && rdy)
      viol++;
    if (tu_o.wr_strobe)
    begin
      wr_q.push_back(tu_o.wr_data);
      if (sb_t == 0)
        sb_t = cyc;
    end
    pv = ch_o;
    pmv = tu_o.move;
  end

  // tape unit: blocks of blen cycles, tape mark flagged in the second cycle of its block
  always @(posedge clk_in)
  begin
    tu_i.rewinding <= tu_o.rewind;
    tu_i.block_end <= 1'b0;
    tu_i.mark_seen <= 1'b0;
    if (tu_o.free_ack)
      free[tu_o.unit] <= 1'b0;
    if (!tu_o.move || tu_o.write)
    begin
      bc = 0;
      bn = 0;
    end
    else
    begin
      bc++;
      if (bc == 2 && bn == mark_at)
        tu_i.mark_seen <= 1'b1;
      if (bc == blen)
      begin
        tu_i.block_end <= 1'b1;
        ends++;
        bc = 0;
        bn++;
      end
    end
  end

  initial
  begin
    rst_in = 1'b1;
    cmd = '0;
    tu_i = '0;
    free = 8'h00;
    rej = 1'b0;
    keep = 3'h6;
    dly = 4'h0;
    blen = 6;
    mark_at = -1;
    foreach (pat[i])
      pat[i] = 8'(rnd());
    repeat (20) @(posedge clk_in);
    chk(ch_o === '0 && rdy === 1'b0, "outputs not cleared in reset");
    rst_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    chk(rdy === 1'b1 && tu_o.rd_check === 1'b1, "not ready after reset");
    for (int k = 0; k < 7; k++)
    begin
      clr();
      keep <= 3'(k);
      issue(TMCS_CMD_SENSE, 3'(rnd()), 1'b0);
      wait_idle();
      n = (k < 6) ? k + 1 : 6;
      chk(sn_q.size() == n, "sense byte count");
      foreach (sn_q[i])
        chk(sn_q[i] === pat[i], "sense byte value");
      chk(st_q.size() == 2 && st_q[0] === ST_NONE, "sense start");
      chk(st_q[1] === (ST_CH_END | ST_DEV_END), "sense end");
    end
    keep <= 3'h6;
    for (int r = 0; r < 2; r++)
    begin
      clr();
      u = 3'(rnd());
      issue(r ? TMCS_CMD_UNLOAD : TMCS_CMD_REWIND, u, 1'b0);
      wait_idle();
      chk(st_q.size() == 1 + r, "rewind status count");
      chk(st_q[0] === ST_CH_END, "rewind initial");
      e = ST_DEV_END | ST_UNIT_CHK | ST_CTRL_END;
      if (r == 1)
        chk(st_q[1] === e, "unload");
      free[u] <= 1'b1;
      wait_idle();
      chk(st_q.size() == 2 + r, "unit free once");
      chk(st_q[$] === ST_DEV_END, "unit free status");
      chk(un_q[$] === u, "unit free address");
    end
    clr();
    rej <= 1'b1;
    u = 3'(rnd());
    v = u ^ 3'h5;
    issue(TMCS_CMD_ERASE, u, 1'b0);
    repeat (4) @(posedge clk_in);
    rej <= 1'b0;
    free[v] <= 1'b1;
    wait_idle();
    chk(st_q.size() == 3 && st_q[0] === ST_CH_END, "erase start");
    chk(st_q[1] === ST_DEV_END, "erase end");
    chk(st_q[2] === ST_DEV_END, "held free");
    chk(un_q.size() == 2 && un_q[0] === u, "order");
    chk(un_q[1] === v, "free after erase");
    chk(rq_t - mv_t >= LPD && wr_q.size() == 0, "erase gap");
    // rejected interrupt status comes back as long busy on the next sense
    clr();
    rej <= 1'b1;
    free[v] <= 1'b1;
    wait_idle();
    rej <= 1'b0;
    chk(st_q.size() == 1, "rejected count");
    clr();
    issue(TMCS_CMD_SENSE, v, 1'b0);
    wait_idle();
    e = ST_DEV_END | ST_BUSY;
    chk(st_q.size() == 1 && st_q[0] === e, "long busy");
    chk(sn_q.size() == 0, "sense ran on held status");
    for (int s = 0; s < 2; s++)
    begin
      clr();
      tu_i.seven_track <= s[0];
      e = s ? MARK_SEVEN : MARK_NINE;
      issue(TMCS_CMD_MARK, 3'(rnd()), 1'b0);
      wait_idle();
      chk(wr_q.size() == 2 && wr_q[0] === e, "mark byte");
      chk(wr_q[1] === e, "mark check char");
      chk(sb_t - mv_t >= MER + STD, "mark written early");
      chk(st_q.size() == 2, "mark status count");
      chk(st_q[1] === ST_DEV_END, "mark end");
    end
    for (int i = 0; i < 9; i++)
    begin
      clr();
      f = (i > 5);
      blen = 4 + int'(rnd() % 8);
      mark_at = f ? int'(rnd() % 3) + 1 : ((rnd() & 1) ? 0 : -1);
      b = 1'(rnd());
      issue(f ? TMCS_CMD_SPACE_FILE : TMCS_CMD_SPACE_BLK, 3'(rnd()), b);
      wait_idle();
      e = (mark_at == 0) ? (ST_DEV_END | ST_UNIT_EXC) : ST_DEV_END;
      n = f ? mark_at + 1 : 1;
      chk(st_q.size() == 2 && st_q[1] === e, "space status");
      chk(bwd === b, "space direction");
      chk(ends == n && rises == 1, "space blocks");
    end
    chk(viol == 0, "tag or unit line misuse");
    summarize();
  end

  // whole run is about a thousand cycles
  initial
  begin
    repeat (50000) @(posedge clk_in);
    failures++;
    summarize();
  end
endmodule
